/* shared/lda_cfg.svh */
`ifndef LDA_CFG_SVH
`define LDA_CFG_SVH

// register offsets on the plain register port
`define LDA_REG_CTRL 4'h0
`define LDA_REG_FF_OVERRIDE 4'h1
`define LDA_REG_VOUT_TARGET 4'h2
`define LDA_REG_TURNS 4'h3
`define LDA_REG_MAX_DUTY 4'h4
`define LDA_REG_GAINS 4'h5
`define LDA_REG_FLUX_LIMIT 4'h6
`define LDA_REG_BURST_ENTRY 4'h7
`define LDA_REG_BURST_VOUT 4'h8
`define LDA_REG_STATUS 4'h9
`define LDA_REG_FF_DUTY 4'hA
`define LDA_REG_VIN_TELEM 4'hB
`define LDA_REG_DUTY_OUT 4'hC

// reset values
`define LDA_RST_CTRL 14'h0000
`define LDA_RST_TURNS 8'h10
`define LDA_RST_MAX_DUTY 16'hFF00
`define LDA_RST_GAINS 16'h8844
`define LDA_RST_FLUX_LIMIT 16'h0100

// current enable thresholds, 1/16 A per lsb
`define LDA_CB_THR_0A 10'h000
`define LDA_CB_THR_3A 10'h030
`define LDA_CB_THR_5A 10'h050

// tolerances, hysteresis, step counts and full-scale duty
`define LDA_FLUX_TOL 22'h000040
`define LDA_BURST_HYST 10'h010
`define LDA_SHARE_TOL 9'h008
`define LDA_SHARE_DIV 4'hF
`define LDA_DIV_STEPS 5'h10
`define LDA_DUTY_FULL 16'hFFFF

`endif

/* shared/lda_pkg.sv */
package lda_pkg;
    // input-voltage source choice
    typedef enum logic [1:0] {
        SRC_RECT_PRIMARY,
        SRC_RECT_SECONDARY,
        SRC_TELEMETRY,
        SRC_OVERRIDE
    } lda_src_type;

    // converter topology
    typedef enum logic [1:0] {
        TOPO_HALF_BRIDGE,
        TOPO_FULL_BRIDGE,
        TOPO_ACF,
        TOPO_BUCK
    } lda_topo_type;

    // light-load state
    typedef enum logic [1:0] {
        ST_RUN,
        ST_BURST_OFF,
        ST_BURST_ON
    } lda_state_type;

    typedef logic [15:0] lda_duty_type;
    typedef logic [10:0] lda_volt_type;
    typedef logic [8:0] lda_amp_type;
endpackage

/* rtl/lda_duty_aug.sv */
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "lda_cfg.svh"
module lda_duty_aug (
    input wire logic clock,
    input wire logic reset,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire lda_pkg::lda_volt_type rect_sense_primary,
    input wire lda_pkg::lda_volt_type rect_sense_secondary,
    input wire lda_pkg::lda_volt_type input_telemetry_sense,
    input wire lda_pkg::lda_volt_type vout_sense,
    input wire lda_pkg::lda_duty_type pid_duty,
    input wire lda_pkg::lda_amp_type phase_current_a,
    input wire lda_pkg::lda_amp_type phase_current_b,
    input wire lda_pkg::lda_amp_type share_bus_level,
    input wire logic sr_conducting,
    input wire logic half_cycle_start,
    input wire logic rect_edge,
    output logic [15:0] reg_rdata,
    output lda_pkg::lda_duty_type duty_phase_a,
    output lda_pkg::lda_duty_type duty_phase_b,
    output logic switching_enable,
    output logic sr_enable,
    output logic pid_hold,
    output logic flux_fault,
    output logic edge_ref_low,
    output logic [7:0] share_current_source,
    output lda_pkg::lda_volt_type vin_telemetry
);
    import lda_pkg::*;

    typedef struct packed {
        lda_state_type state;
        logic [13:0] ctrl;
        lda_volt_type ff_rect_voltage_override;
        lda_volt_type vout_target;
        logic [7:0] turns;
        lda_duty_type max_duty;
        logic [15:0] gains;
        logic [15:0] flux_limit;
        logic [9:0] burst_entry;
        lda_volt_type burst_vout;
        logic [15:0] rdata;
        logic div_busy;
        logic [4:0] div_cnt;
        logic [15:0] div_rem;
        logic [14:0] div_den;
        lda_duty_type div_q;
        lda_volt_type div_vin;
        lda_duty_type ff_duty;
        logic signed [1:0][17:0] cb_integ;
        logic cb_active;
        logic half;
        logic [9:0] on_cnt;
        logic [20:0] vs_first;
        logic signed [21:0] flux_integ;
        logic [15:0] flux_cnt;
        logic flux_fault;
        lda_duty_type pid_frozen;
        logic [3:0] share_cnt;
        logic share_balanced;
        lda_duty_type duty_a;
        lda_duty_type duty_b;
        logic sw_en;
        logic sr_en;
        logic [7:0] share_out;
        lda_volt_type vin_telem;
    } lda_regs_type;

    lda_regs_type r;
    lda_regs_type next_r;

    // control field views
    lda_src_type ff_src;
    lda_topo_type topo;
    logic ff_en;
    logic cb_en;
    logic flux_en;
    logic burst_en;
    logic [1:0] cb_thr_sel;
    lda_src_type telem_src;
    logic ff_without_sr;

    assign ff_src = lda_src_type'(r.ctrl[1:0]);
    assign topo = lda_topo_type'(r.ctrl[3:2]);
    assign ff_en = r.ctrl[4];
    assign cb_en = r.ctrl[5];
    assign flux_en = r.ctrl[6];
    assign burst_en = r.ctrl[7];
    assign cb_thr_sel = r.ctrl[9:8];
    assign telem_src = lda_src_type'(r.ctrl[12:11]);
    assign ff_without_sr = r.ctrl[13];

    always_comb begin
        lda_volt_type vin_ff;
        logic [19:0] num;
        logic [16:0] rem2;
        logic [9:0] total;
        logic [9:0] cb_thr;
        logic signed [10:0] cb_err;
        logic signed [18:0] cb_corr [2];
        logic [20:0] vs_now;
        logic signed [21:0] vs_err;
        logic [21:0] vs_mag;
        logic signed [15:0] flux_corr;
        lda_duty_type pid_use;
        logic signed [19:0] base;
        logic signed [19:0] sum [2];
        logic [9:0] share_own;
        logic [8:0] share_diff;
        vin_ff = '0;
        num = '0;
        rem2 = '0;
        total = '0;
        cb_thr = '0;
        cb_err = '0;
        cb_corr[0] = '0;
        cb_corr[1] = '0;
        vs_now = '0;
        vs_err = '0;
        vs_mag = '0;
        flux_corr = '0;
        pid_use = '0;
        base = '0;
        sum[0] = '0;
        sum[1] = '0;
        share_own = '0;
        share_diff = '0;
        next_r = r;

        // register writes; the fault clear loses to a new fault below
        if (reg_write) begin
            if (reg_addr == `LDA_REG_CTRL) begin
                next_r.ctrl = reg_wdata[13:0];
            end else if (reg_addr == `LDA_REG_FF_OVERRIDE) begin
                next_r.ff_rect_voltage_override = reg_wdata[10:0];
            end else if (reg_addr == `LDA_REG_VOUT_TARGET) begin
                next_r.vout_target = reg_wdata[10:0];
            end else if (reg_addr == `LDA_REG_TURNS) begin
                next_r.turns = reg_wdata[7:0];
            end else if (reg_addr == `LDA_REG_MAX_DUTY) begin
                next_r.max_duty = reg_wdata;
            end else if (reg_addr == `LDA_REG_GAINS) begin
                next_r.gains = reg_wdata;
            end else if (reg_addr == `LDA_REG_FLUX_LIMIT) begin
                next_r.flux_limit = reg_wdata;
            end else if (reg_addr == `LDA_REG_BURST_ENTRY) begin
                next_r.burst_entry = reg_wdata[9:0];
            end else if (reg_addr == `LDA_REG_BURST_VOUT) begin
                next_r.burst_vout = reg_wdata[10:0];
            end else if (reg_addr == `LDA_REG_STATUS) begin
                if (reg_wdata[0]) begin
                    next_r.flux_fault = 1'b0;
                end
            end
        end

        // read data valid in the cycle after the strobe only
        next_r.rdata = 16'h0000;
        if (reg_read) begin
            if (reg_addr == `LDA_REG_CTRL) begin
                next_r.rdata = {2'h0, r.ctrl};
            end else if (reg_addr == `LDA_REG_FF_OVERRIDE) begin
                next_r.rdata = {5'h00, r.ff_rect_voltage_override};
            end else if (reg_addr == `LDA_REG_VOUT_TARGET) begin
                next_r.rdata = {5'h00, r.vout_target};
            end else if (reg_addr == `LDA_REG_TURNS) begin
                next_r.rdata = {8'h00, r.turns};
            end else if (reg_addr == `LDA_REG_MAX_DUTY) begin
                next_r.rdata = r.max_duty;
            end else if (reg_addr == `LDA_REG_GAINS) begin
                next_r.rdata = r.gains;
            end else if (reg_addr == `LDA_REG_FLUX_LIMIT) begin
                next_r.rdata = r.flux_limit;
            end else if (reg_addr == `LDA_REG_BURST_ENTRY) begin
                next_r.rdata = {6'h00, r.burst_entry};
            end else if (reg_addr == `LDA_REG_BURST_VOUT) begin
                next_r.rdata = {5'h00, r.burst_vout};
            end else if (reg_addr == `LDA_REG_STATUS) begin
                next_r.rdata = {10'h000, r.state, r.share_balanced, r.cb_active,
                    r.state != ST_RUN, r.flux_fault};
            end else if (reg_addr == `LDA_REG_FF_DUTY) begin
                next_r.rdata = r.ff_duty;
            end else if (reg_addr == `LDA_REG_VIN_TELEM) begin
                next_r.rdata = {5'h00, r.vin_telem};
            end else if (reg_addr == `LDA_REG_DUTY_OUT) begin
                next_r.rdata = r.duty_a;
            end
        end

        // feedforward input source
        case (ff_src)
            SRC_RECT_PRIMARY: vin_ff = rect_sense_primary;
            SRC_RECT_SECONDARY: vin_ff = rect_sense_secondary;
            SRC_TELEMETRY: vin_ff = input_telemetry_sense;
            default: vin_ff = r.ff_rect_voltage_override;
        endcase

        // telemetry source has its own selector
        case (telem_src)
            SRC_RECT_PRIMARY: next_r.vin_telem = rect_sense_primary;
            SRC_RECT_SECONDARY: next_r.vin_telem = rect_sense_secondary;
            SRC_TELEMETRY: next_r.vin_telem = input_telemetry_sense;
            default: next_r.vin_telem = r.ff_rect_voltage_override;
        endcase

        // nominal duty divide, started again when the sensed input has moved and no divide is running
        if (!r.div_busy && vin_ff != r.div_vin) begin
            next_r.div_vin = vin_ff;
            case (topo)
                // product widened first so turns times target cannot wrap
                TOPO_HALF_BRIDGE: num = {19'(r.turns) * 19'(r.vout_target), 1'b0};
                TOPO_BUCK: num = {5'h00, r.vout_target, 4'h0};
                default: num = {1'b0, 19'(r.turns) * 19'(r.vout_target)};
            endcase
            if (vin_ff == 11'h000 || num >= {1'b0, vin_ff, 4'h0}) begin
                next_r.ff_duty = `LDA_DUTY_FULL;
            end else begin
                next_r.div_busy = 1'b1;
                next_r.div_cnt = 5'h00;
                next_r.div_rem = num[15:0];
                next_r.div_den = {vin_ff, 4'h0};
                next_r.div_q = 16'h0000;
            end
        end else if (r.div_busy) begin
            // one quotient bit per clock, 16 clocks per result
            rem2 = {r.div_rem, 1'b0};
            if (rem2 >= {2'h0, r.div_den}) begin
                next_r.div_rem = 16'(rem2 - {2'h0, r.div_den});
                next_r.div_q = {r.div_q[14:0], 1'b1};
            end else begin
                next_r.div_rem = rem2[15:0];
                next_r.div_q = {r.div_q[14:0], 1'b0};
            end
            next_r.div_cnt = 5'(r.div_cnt + 5'h01);
            if (r.div_cnt == `LDA_DIV_STEPS - 5'h01) begin
                next_r.div_busy = 1'b0;
                next_r.ff_duty = next_r.div_q;
            end
        end

        // phase current balance
        total = {1'b0, phase_current_a} + {1'b0, phase_current_b};
        case (cb_thr_sel)
            2'h1: cb_thr = `LDA_CB_THR_3A;
            2'h2: cb_thr = `LDA_CB_THR_5A;
            default: cb_thr = `LDA_CB_THR_0A;
        endcase
        next_r.cb_active = cb_en && total > cb_thr;
        for (int p = 0; p < 2; p++) begin
            cb_err = $signed({2'h0, total[9:1]})
                - $signed({2'h0, (p == 0) ? phase_current_a : phase_current_b});
            if (!r.cb_active) begin
                next_r.cb_integ[p] = '0;
            end else if (half_cycle_start) begin
                next_r.cb_integ[p] = r.cb_integ[p] + 18'(cb_err >>> r.gains[7:4]);
            end
            cb_corr[p] = r.cb_active ? 19'(cb_err >>> r.gains[3:0])
                + 19'($signed(r.cb_integ[p]) >>> 4) : 19'sh00000;
        end

        // rectified-voltage high time per half cycle from the edge comparator
        if (half_cycle_start) begin
            next_r.on_cnt = 10'h000;
            next_r.half = !r.half;
            vs_now = 21'(r.on_cnt) * 21'(vin_ff);
            if (!r.half) begin
                next_r.vs_first = vs_now;
            end else begin
                vs_err = $signed({1'b0, r.vs_first}) - $signed({1'b0, vs_now});
                vs_mag = vs_err[21] ? 22'(-vs_err) : vs_err;
                if (flux_en) begin
                    next_r.flux_integ = r.flux_integ + (vs_err >>> r.gains[15:12]);
                    if (vs_mag > `LDA_FLUX_TOL) begin
                        next_r.flux_cnt = (r.flux_cnt == 16'hFFFF) ? r.flux_cnt
                            : 16'(r.flux_cnt + 16'h0001);
                    end else begin
                        next_r.flux_cnt = 16'h0000;
                    end
                end else begin
                    next_r.flux_integ = '0;
                    next_r.flux_cnt = 16'h0000;
                end
            end
        end else if (rect_edge && r.on_cnt != 10'h3FF) begin
            // 8 ns counting step, coarser than the comparator itself
            next_r.on_cnt = 10'(r.on_cnt + 10'h001);
        end
        // the fault set wins over a same-cycle software clear
        if (flux_en && r.flux_limit != 16'h0000 && r.flux_cnt >= r.flux_limit) begin
            next_r.flux_fault = 1'b1;
        end
        flux_corr = flux_en ? 16'(r.flux_integ >>> r.gains[11:8]) : 16'sh0000;

        // light-load burst sequencing, changes only at cycle boundaries
        case (r.state)
            ST_RUN: begin
                if (burst_en && total < r.burst_entry && half_cycle_start) begin
                    next_r.state = ST_BURST_OFF;
                    next_r.pid_frozen = pid_duty;
                end
            end
            ST_BURST_OFF: begin
                if (!burst_en || total >= 10'(r.burst_entry + `LDA_BURST_HYST)) begin
                    next_r.state = half_cycle_start ? ST_RUN : ST_BURST_OFF;
                end else if (vout_sense <= r.burst_vout && half_cycle_start) begin
                    next_r.state = ST_BURST_ON;
                end
            end
            ST_BURST_ON: begin
                if (!burst_en || total >= 10'(r.burst_entry + `LDA_BURST_HYST)) begin
                    next_r.state = half_cycle_start ? ST_RUN : ST_BURST_ON;
                end else if (vout_sense >= r.vout_target && half_cycle_start) begin
                    next_r.state = ST_BURST_OFF;
                end
            end
            default: next_r.state = ST_RUN;
        endcase
        next_r.sw_en = next_r.state != ST_BURST_OFF;
        next_r.sr_en = next_r.state == ST_RUN;

        // sum the enabled corrections with the compensator, feedforward only while sr_conducting or ff_without_sr, then clamp
        pid_use = (r.state == ST_RUN) ? pid_duty : r.pid_frozen;
        base = $signed({4'h0, pid_use});
        if (ff_en && (sr_conducting || ff_without_sr)) begin
            base = base + $signed({4'h0, r.ff_duty});
        end
        for (int p = 0; p < 2; p++) begin
            sum[p] = base + 20'(cb_corr[p]);
            sum[p] = r.half ? sum[p] - 20'(flux_corr) : sum[p] + 20'(flux_corr);
            if (sum[p] < 20'sh00000) begin
                sum[p] = 20'sh00000;
            end else if (sum[p] > $signed({4'h0, r.max_duty})) begin
                sum[p] = $signed({4'h0, r.max_duty});
            end
        end
        next_r.duty_a = sum[0][15:0];
        next_r.duty_b = sum[1][15:0];

        // share source follows load; bus level judged once per 16 half cycles
        next_r.share_out = total[9:2];
        share_own = {1'b0, r.share_out, 1'b0};
        if (half_cycle_start) begin
            next_r.share_cnt = 4'(r.share_cnt + 4'h1);
            if (r.share_cnt == `LDA_SHARE_DIV) begin
                share_diff = (share_own[8:0] > share_bus_level)
                    ? 9'(share_own[8:0] - share_bus_level)
                    : 9'(share_bus_level - share_own[8:0]);
                next_r.share_balanced = share_diff <= `LDA_SHARE_TOL;
            end
        end
    end

    // single state register, synchronous reset
    always_ff @(posedge clock) begin
        if (reset) begin
            r <= '0;
            r.state <= ST_RUN;
            r.ctrl <= `LDA_RST_CTRL;
            r.turns <= `LDA_RST_TURNS;
            r.max_duty <= `LDA_RST_MAX_DUTY;
            r.gains <= `LDA_RST_GAINS;
            r.flux_limit <= `LDA_RST_FLUX_LIMIT;
            r.sw_en <= 1'b1;
            r.sr_en <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign reg_rdata = r.rdata;
    assign duty_phase_a = r.duty_a;
    assign duty_phase_b = r.duty_b;
    assign switching_enable = r.sw_en;
    assign sr_enable = r.sr_en;
    assign pid_hold = r.state != ST_RUN; // decoded from the state flops
    assign flux_fault = r.flux_fault;
    assign edge_ref_low = r.ctrl[10];
    assign share_current_source = r.share_out;
    assign vin_telemetry = r.vin_telem;
endmodule // lda_duty_aug

/* tb/lda_aug_assertions.sv */
`timescale 1ns/1ps
`include "lda_cfg.svh"
module lda_aug_checker (
    input wire logic clock,
    input wire logic reset,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic half_cycle_start,
    input wire logic [15:0] reg_rdata,
    input wire logic switching_enable,
    input wire logic sr_enable,
    input wire logic pid_hold,
    input wire logic flux_fault,
    input wire logic edge_ref_low
);
    import lda_pkg::*;
    logic clear_req;
    default clocking @(posedge clock);
    endclocking
    default disable iff (reset);
    // software clear of the sticky fault
    assign clear_req = reg_write && reg_addr == `LDA_REG_STATUS && reg_wdata[0];
    sequence s_ctrl_write;
        reg_write && reg_addr == `LDA_REG_CTRL;
    endsequence
    sequence s_burst_entry;
        $rose(pid_hold);
    endsequence
    property p_rd_idle;
        !reg_read |=> reg_rdata == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data left standing");
    property p_burst_sr_off;
        pid_hold |-> !sr_enable;
    endproperty
    a_burst_sr_off: assert property (p_burst_sr_off) else $error("rectifier on in burst");
    property p_run_on;
        !pid_hold |-> switching_enable && sr_enable;
    endproperty
    a_run_on: assert property (p_run_on) else $error("run state not switching");
    property p_entry_off;
        s_burst_entry |-> !switching_enable;
    endproperty
    a_entry_off: assert property (p_entry_off) else $error("burst entry still switching");
    property p_sw_step;
        $changed(switching_enable) && !$past(reset) |-> $past(half_cycle_start);
    endproperty
    a_sw_step: assert property (p_sw_step) else $error("switching moved off boundary");
    property p_hold_step;
        $changed(pid_hold) && !$past(reset) |-> $past(half_cycle_start);
    endproperty
    a_hold_step: assert property (p_hold_step) else $error("hold moved off boundary");
    property p_fault_sticky;
        flux_fault && !clear_req |=> flux_fault;
    endproperty
    a_fault_sticky: assert property (p_fault_sticky) else $error("fault dropped");
    property p_edge_ref;
        s_ctrl_write |=> edge_ref_low == $past(reg_wdata[10]);
    endproperty
    a_edge_ref: assert property (p_edge_ref) else $error("reference select lost");
endmodule // lda_aug_checker

bind lda_duty_aug lda_aug_checker u_checker (
    .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .half_cycle_start(half_cycle_start),
    .reg_rdata(reg_rdata), .switching_enable(switching_enable), .sr_enable(sr_enable),
    .pid_hold(pid_hold), .flux_fault(flux_fault), .edge_ref_low(edge_ref_low)
);

/* tb/lda_stage_model.sv */
`timescale 1ns/1ps
module lda_stage_model #(
    parameter int HALF_LEN = 20
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic imbalance,
    input wire logic switching_enable,
    input wire logic sr_enable,
    output logic half_cycle_start,
    output logic rect_edge,
    output logic sr_conducting
);
    int count = 0;
    logic odd = 1'b0;
    // period stays fixed in burst too, so boundaries keep coming
    always_ff @(posedge clock) begin
        count <= (reset || count == HALF_LEN - 1) ? 0 : count + 1;
        if (count == HALF_LEN - 1)
            odd <= !odd;
    end
    assign half_cycle_start = !reset && count == 0;
    // odd half cut short on command, leaving a volt-second gap
    assign rect_edge = switching_enable && count < ((odd && imbalance) ? 4 : 8);
    // channel conducts only while the rectifiers are driven
    assign sr_conducting = sr_enable && switching_enable;
endmodule // lda_stage_model

/* tb/test_lda_duty_aug.sv */
`timescale 1ns/1ps
`include "lda_cfg.svh"
module test_lda_duty_aug;
    import lda_pkg::*;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    lda_volt_type vout = 11'h190;
    lda_duty_type pid = 16'h0000;
    lda_amp_type cur_a = 9'h020;
    lda_amp_type cur_b = 9'h020;
    logic imbal = 1'b0;
    logic hcs, edge_in, sr_cond, sw_en, sr_en, hold, fault, ref_low;
    logic [15:0] rdata, got;
    lda_duty_type duty_a, duty_b;
    logic [7:0] share;
    lda_volt_type vin_tel;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    int vin [4] = '{2000, 1000, 1600, 1250};
    int thr [3] = '{0, 48, 80};

    always #4 clock = !clock;

    lda_duty_aug dut (
        .clock(clock), .reset(reset), .reg_addr(addr), .reg_wdata(wdata), .reg_write(wr_s),
        .reg_read(rd_s), .rect_sense_primary(11'h7D0), .rect_sense_secondary(11'h3E8),
        .input_telemetry_sense(11'h640), .vout_sense(vout), .pid_duty(pid),
        .phase_current_a(cur_a), .phase_current_b(cur_b), .share_bus_level(9'h000),
        .sr_conducting(sr_cond), .half_cycle_start(hcs), .rect_edge(edge_in),
        .reg_rdata(rdata), .duty_phase_a(duty_a), .duty_phase_b(duty_b),
        .switching_enable(sw_en), .sr_enable(sr_en), .pid_hold(hold), .flux_fault(fault),
        .edge_ref_low(ref_low), .share_current_source(share), .vin_telemetry(vin_tel)
    );
    lda_stage_model u_stage (
        .clock(clock), .reset(reset), .imbalance(imbal), .switching_enable(sw_en),
        .sr_enable(sr_en), .half_cycle_start(hcs), .rect_edge(edge_in), .sr_conducting(sr_cond)
    );

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clock);
        wr_s <= 1'b0;
    endtask
    // read data only stand one cycle, so it is caught just past the edge
    task automatic rd(input logic [3:0] a);
        @(posedge clock);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clock);
        rd_s <= 1'b0;
        #1 got = rdata;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    function automatic logic [15:0] ff_exp(input int topo, input int v);
        int n;
        n = (topo == 3) ? 16 * 400 : 32 * 400 * ((topo == 0) ? 2 : 1);
        return 16'(n * 4096 / v);
    endfunction

    task automatic t_regs();
        rd(`LDA_REG_TURNS);
        chk(got, 16'h0010);
        rd(`LDA_REG_MAX_DUTY);
        chk(got, 16'hFF00);
        wr(4'hF, 16'hFFFF);
        rd(4'hF);
        chk(got, 16'h0000);
    endtask
    // each pass changes source, and topology on all but the first, so every divide restarts
    task automatic t_ff();
        wr(`LDA_REG_VOUT_TARGET, 16'h0190);
        wr(`LDA_REG_TURNS, 16'h0020);
        wr(`LDA_REG_FF_OVERRIDE, 16'h04E2);
        // park on the override so the first pass sees a source change
        wr(`LDA_REG_CTRL, 16'h0003);
        settle(20);
        for (int i = 0; i < 4; i++) begin
            wr(`LDA_REG_CTRL, 16'(16 + 5 * i));
            settle(24);
            rd(`LDA_REG_FF_DUTY);
            chk(got, ff_exp(i, vin[i]));
            chk(duty_a, ff_exp(i, vin[i]));
        end
        @(posedge clock);
        pid <= 16'h1000;
        settle(3);
        chk(duty_b, 16'h61EB);
        wr(`LDA_REG_MAX_DUTY, 16'h2000);
        settle(3);
        chk(duty_a, 16'h2000);
        wr(`LDA_REG_CTRL, 16'h1400);
        settle(3);
        chk(duty_a, 16'h1000);
        chk(16'(vin_tel), 16'h0640);
        chk(16'(ref_low), 16'h0001);
        wr(`LDA_REG_MAX_DUTY, 16'hFF00);
    endtask
    task automatic t_balance();
        for (int s = 0; s < 3; s++) begin
            wr(`LDA_REG_CTRL, 16'(32 + 256 * s));
            settle(45);
            rd(`LDA_REG_STATUS);
            chk(16'(got[2]), 16'(64 > thr[s]));
        end
        wr(`LDA_REG_CTRL, 16'h0020);
        @(posedge clock);
        cur_a <= 9'h030;
        cur_b <= 9'h010;
        pid <= 16'h8000;
        settle(200);
        chk(16'(duty_a < duty_b), 16'h0001);
        chk(16'(share), 16'h0010);
    endtask
    task automatic t_burst();
        wr(`LDA_REG_BURST_ENTRY, 16'h0040);
        wr(`LDA_REG_BURST_VOUT, 16'h012C);
        @(posedge clock);
        cur_a <= 9'h010;
        wr(`LDA_REG_CTRL, 16'h0080);
        settle(45);
        chk(16'({sw_en, sr_en, hold}), 16'h0001);
        @(posedge clock);
        vout <= 11'h122;
        settle(45);
        chk(16'({sw_en, sr_en, hold}), 16'h0005);
        @(posedge clock);
        cur_a <= 9'h030;
        cur_b <= 9'h030;
        settle(45);
        chk(16'({sw_en, sr_en, hold}), 16'h0006);
    endtask
    task automatic t_flux();
        wr(`LDA_REG_FLUX_LIMIT, 16'h0004);
        wr(`LDA_REG_CTRL, 16'h0040);
        settle(200);
        chk(16'(fault), 16'h0000);
        @(posedge clock);
        imbal <= 1'b1;
        settle(300);
        rd(`LDA_REG_STATUS);
        chk(16'(got[0]), 16'h0001);
        @(posedge clock);
        imbal <= 1'b0;
        // let a balanced pair reset the count, else the set wins over the clear
        settle(100);
        wr(`LDA_REG_STATUS, 16'h0001);
        settle(5);
        chk(16'(fault), 16'h0000);
    endtask

    task automatic close_out();
        if (num_errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // hang guard well beyond the run length
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            close_out();
        end
    end
    initial begin
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        t_regs();
        t_ff();
        t_balance();
        t_burst();
        t_flux();
        close_out();
    end
endmodule // test_lda_duty_aug
